// [logic/wpi_pkg.sv]
// Package for the receive path pointer interpreter and path overhead block.
// Assumes a 16-bit register port and one clock shared with the frame logic.
package wpi_pkg;
  // Pointer interpreter states
  typedef enum logic [1:0] {
    ST_POINTER_NORMAL_STATE = 2'b00,
    ST_LOP = 2'b01,
    ST_AIS = 2'b10
  } wpi_state_e;

  // Register offsets (word index on the register port)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PATH_STATUS = 8'h01;
  localparam logic [7:0] OFS_PENDING = 8'h02;
  localparam logic [7:0] OFS_MASK_A = 8'h03;
  localparam logic [7:0] OFS_MASK_B = 8'h04;
  localparam logic [7:0] OFS_TX_SIGNAL_LABEL = 8'h05;
  localparam logic [7:0] OFS_EXP_C2 = 8'h06;
  localparam logic [7:0] OFS_TX_USER_CHANNEL = 8'h07;
  localparam logic [7:0] OFS_TX_MULTIFRAME_IND = 8'h08;
  localparam logic [7:0] OFS_TX_GROWTH_A = 8'h09;
  localparam logic [7:0] OFS_TX_GROWTH_B = 8'h0A;
  localparam logic [7:0] OFS_TX_TANDEM_OCTET = 8'h0B;
  localparam logic [7:0] OFS_PTR = 8'h0C;

  // Control register fields
  localparam int CTRL_SDH = 0;
  localparam int CTRL_ERDI = 1;
  localparam int CTRL_TXLEN = 4;
  localparam int CTRL_RXLEN = 6;
  // Status and pending bit positions
  localparam int BIT_AIS = 0;
  localparam int BIT_LOP = 1;
  localparam int BIT_PLM = 2;
  localparam int BIT_CONC = 3;
  localparam int STAT_STATE = 4;

  // Reset values and trace length codes
  localparam logic [7:0] RST_SIGNAL_LABEL = 8'h1A;
  localparam logic [7:0] RST_OCTET = 8'h00;
  localparam logic [1:0] TRACE_16 = 2'h0;
  localparam logic [1:0] TRACE_1 = 2'h1;
  localparam logic [1:0] TRACE_64 = 2'h2;

  // Pointer word coding
  localparam logic [9:0] PTR_MAX = 10'h30E;
  localparam logic [9:0] PTR_ONES = 10'h3FF;
  localparam logic [9:0] I_MASK = 10'h2AA;
  localparam logic [9:0] D_MASK = 10'h155;
  localparam logic [3:0] FLAG_NEW = 4'h9;
  localparam logic [3:0] FLAG_POINTER_NORMAL_STATE = 4'h6;
  localparam logic [1:0] SS_SDH = 2'h2;
  localparam logic [15:0] AIS_WORD = 16'hFFFF;
  localparam logic [3:0] PTR_BITS = 4'hA;
  localparam logic [3:0] SONET_MATCH = 4'h8;
  localparam logic [3:0] SDH_MAJ = 4'h3;
  localparam logic [3:0] SDH_MIN = 4'h2;

  // Frame persistence counts
  localparam logic [1:0] HOLD_FRAMES = 2'h3;
  localparam logic [1:0] POINTER_NORMAL_STATE_FRAMES = 2'h3;
  localparam logic [1:0] AIS_FRAMES = 2'h3;
  localparam logic [3:0] LOP_FRAMES = 4'h8;
  localparam logic [2:0] C2_FRAMES = 3'h5;
endpackage

// [logic/wpi_pointer_interp.sv]
// Receive payload pointer interpreter with path alarms and static path overhead.
// Assumes frame logic on CLK gives one FRAME_STB pulse per frame with its words.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module wpi_pointer_interp
  import wpi_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire logic FRAME_STB,
  input wire logic [15:0] RX_PTR_WORD,
  input wire logic [15:0] RX_CONC_WORD,
  input wire logic [7:0] RX_C2,
  output logic [1:0] PTR_STATE,
  output logic [9:0] PTR_VALUE,
  output logic PTR_INC,
  output logic PTR_DEC,
  output logic LABEL_MISMATCH,
  output logic IRQ_OUT_A,
  output logic IRQ_OUT_B,
  output logic [7:0] TX_SIGNAL_LABEL,
  output logic [7:0] TX_USER_CHANNEL,
  output logic [7:0] TX_MULTIFRAME_IND,
  output logic [7:0] TX_GROWTH_A,
  output logic [7:0] TX_GROWTH_B,
  output logic [7:0] TX_TANDEM_OCTET,
  output logic [1:0] TX_TRACE_LENGTH,
  output logic [1:0] RX_TRACE_LENGTH,
  output logic TX_ERDI_SEL
);

  typedef struct packed {
    wpi_state_e state;
    logic [9:0] ptr;
    logic have_ptr;
    logic [1:0] hold;
    logic [9:0] cand;
    logic [1:0] cand_cnt;
    logic [1:0] ais_cnt;
    logic [3:0] inv_cnt;
    logic [7:0] c2_cand;
    logic [2:0] c2_cnt;
    logic [7:0] c2_acc;
    logic plm;
    logic conc_err;
    logic inc;
    logic dec;
    logic sdh;
    logic erdi;
    logic [1:0] tx_len;
    logic [1:0] rx_len;
    logic [7:0] tx_signal_label;
    logic [7:0] exp_c2;
    logic [7:0] f2;
    logic [7:0] h4;
    logic [7:0] z3;
    logic [7:0] z4;
    logic [7:0] n1;
    logic [1:0] mask_a;
    logic [1:0] mask_b;
    logic [1:0] pend;
    logic [1:0] latch;
    logic [15:0] rdata;
    logic irq_a;
    logic irq_b;
  } wpi_regs_s;

  wpi_regs_s r;
  wpi_regs_s next_r;

  // Ones count of a ten-bit pattern
  function automatic logic [3:0] pop10(input logic [9:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 10; i++) begin
      c = c + {3'b000, v[i]};
    end
    return c;
  endfunction

  // Decoded fields of the primary pointer word
  logic [3:0] flag;
  logic [1:0] ss;
  logic [9:0] pval;
  logic flag_new;
  logic flag_pointer_normal_state;
  logic ss_ok;
  logic in_range;
  logic ais_ptr;
  logic [3:0] inv_i;
  logic [3:0] inv_d;
  logic [3:0] miss_inc;
  logic [3:0] miss_dec;
  logic inc_hit;
  logic dec_hit;
  logic just_ok;
  logic inc_acc;
  logic dec_acc;
  logic ndf_acc;
  logic pointer_normal_state_hit;
  logic pointer_normal_state_done;
  logic ais_done;
  logic valid_ptr;
  logic lop_done;
  logic ais_chg;
  logic lop_chg;
  logic rd_status;
  logic rd_pend;

  always_comb begin
    flag = RX_PTR_WORD[15:12];
    ss = RX_PTR_WORD[11:10];
    pval = RX_PTR_WORD[9:0];
    flag_new = pop10({6'h00, flag ^ FLAG_NEW}) <= 4'h1;
    flag_pointer_normal_state = pop10({6'h00, flag ^ FLAG_POINTER_NORMAL_STATE}) <= 4'h1;
    ss_ok = !r.sdh || (ss == SS_SDH);
    in_range = pval <= PTR_MAX;
    ais_ptr = RX_PTR_WORD == AIS_WORD;
    inv_i = pop10((pval ^ r.ptr) & I_MASK);
    inv_d = pop10((pval ^ r.ptr) & D_MASK);
    miss_inc = pop10(pval ^ (r.ptr ^ I_MASK));
    miss_dec = pop10(pval ^ (r.ptr ^ D_MASK));
    if (r.sdh) begin
      inc_hit = (inv_i >= SDH_MAJ) && (inv_d <= SDH_MIN);
      dec_hit = (inv_d >= SDH_MAJ) && (inv_i <= SDH_MIN);
    end else begin
      inc_hit = (PTR_BITS - miss_inc) >= SONET_MATCH;
      dec_hit = (PTR_BITS - miss_dec) >= SONET_MATCH;
    end
    // justification only in normal and outside hold-off
    just_ok = FRAME_STB && r.state == ST_POINTER_NORMAL_STATE && r.have_ptr && flag_pointer_normal_state && ss_ok
      && r.hold == 2'h0 && pval != r.ptr;
    inc_acc = just_ok && inc_hit;
    dec_acc = just_ok && dec_hit;
    // new data flag accepted outside loss of pointer
    ndf_acc = FRAME_STB && r.state != ST_LOP && flag_new && ss_ok && in_range;
    // identical normal pointers, restarted on a break
    pointer_normal_state_hit = FRAME_STB && flag_pointer_normal_state && ss_ok && in_range;
    pointer_normal_state_done = pointer_normal_state_hit && r.cand_cnt != 2'h0 && pval == r.cand
      && r.cand_cnt == POINTER_NORMAL_STATE_FRAMES - 2'h1;
    ais_done = FRAME_STB && ais_ptr && r.state != ST_AIS && r.ais_cnt == AIS_FRAMES - 2'h1;
    // valid pointer for the loss count
    if (r.state == ST_AIS) begin
      valid_ptr = ais_ptr || ndf_acc || pointer_normal_state_done;
    end else begin
      valid_ptr = ais_ptr || ndf_acc || pointer_normal_state_done || inc_acc || dec_acc
        || (flag_pointer_normal_state && ss_ok && r.have_ptr && pval == r.ptr);
    end
    lop_done = FRAME_STB && !valid_ptr && r.state != ST_LOP
      && r.inv_cnt == LOP_FRAMES - 4'h1;
    rd_status = REG_RD && REG_ADDR == OFS_PATH_STATUS;
    rd_pend = REG_RD && REG_ADDR == OFS_PENDING;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block
  always_comb begin
    next_r = r;
    next_r.inc = 1'b0;
    next_r.dec = 1'b0;
    if (FRAME_STB) begin
      if (r.hold != 2'h0) begin
        next_r.hold = r.hold - 2'h1;
      end
      if (pointer_normal_state_hit) begin
        if (r.cand_cnt != 2'h0 && pval == r.cand) begin
          next_r.cand_cnt = (r.cand_cnt == POINTER_NORMAL_STATE_FRAMES) ? r.cand_cnt : r.cand_cnt + 2'h1;
        end else begin
          next_r.cand = pval;
          next_r.cand_cnt = 2'h1;
        end
      end else begin
        next_r.cand_cnt = 2'h0;
      end
      if (ais_ptr) begin
        next_r.ais_cnt = (r.ais_cnt == AIS_FRAMES) ? r.ais_cnt : r.ais_cnt + 2'h1;
      end else begin
        next_r.ais_cnt = 2'h0;
      end
      // invalid run restarts on a valid pointer
      if (valid_ptr || r.state == ST_LOP) begin
        next_r.inv_cnt = 4'h0;
      end else if (r.inv_cnt != LOP_FRAMES) begin
        next_r.inv_cnt = r.inv_cnt + 4'h1;
      end
      // transitions; new pointer wins over alarm and loss
      if (ndf_acc) begin
        next_r.state = ST_POINTER_NORMAL_STATE;
        next_r.ptr = pval;
        next_r.have_ptr = 1'b1;
        next_r.hold = HOLD_FRAMES;
      end else if (pointer_normal_state_done) begin
        next_r.state = ST_POINTER_NORMAL_STATE;
        next_r.ptr = pval;
        next_r.have_ptr = 1'b1;
      end else if (ais_done) begin
        next_r.state = ST_AIS;
      end else if (lop_done) begin
        next_r.state = ST_LOP;
        next_r.have_ptr = 1'b0;
      end else if (inc_acc) begin
        next_r.ptr = (r.ptr == PTR_MAX) ? 10'h000 : r.ptr + 10'h001;
        next_r.hold = HOLD_FRAMES;
        next_r.inc = 1'b1;
      end else if (dec_acc) begin
        next_r.ptr = (r.ptr == 10'h000) ? PTR_MAX : r.ptr - 10'h001;
        next_r.hold = HOLD_FRAMES;
        next_r.dec = 1'b1;
      end
      // concatenation word must be flag-new all-ones or all-ones alarm
      next_r.conc_err = !((RX_CONC_WORD == AIS_WORD)
        || (RX_CONC_WORD[15:12] == FLAG_NEW && RX_CONC_WORD[9:0] == PTR_ONES
        && (!r.sdh || RX_CONC_WORD[11:10] == SS_SDH))
        || (pop10({6'h00, RX_CONC_WORD[15:12] ^ FLAG_NEW}) <= 4'h1
        && RX_CONC_WORD[9:0] == PTR_ONES && (!r.sdh || RX_CONC_WORD[11:10] == SS_SDH)));
      // label accepted after five equal frames, then compared
      if (RX_C2 == r.c2_cand) begin
        if (r.c2_cnt != C2_FRAMES) begin
          next_r.c2_cnt = r.c2_cnt + 3'h1;
        end
      end else begin
        next_r.c2_cand = RX_C2;
        next_r.c2_cnt = 3'h1;
      end
      if (RX_C2 == r.c2_cand && r.c2_cnt == C2_FRAMES - 3'h1) begin
        next_r.c2_acc = RX_C2;
      end
    end
    next_r.plm = next_r.c2_acc != 8'h00 && next_r.c2_acc != r.exp_c2;

    // State change events
    ais_chg = (r.state == ST_AIS) != (next_r.state == ST_AIS);
    lop_chg = (r.state == ST_LOP) != (next_r.state == ST_LOP);

    // latch-high: a read reloads status, an event in that cycle wins
    next_r.latch[BIT_AIS] = ais_chg
      || (rd_status ? (next_r.state == ST_AIS) : r.latch[BIT_AIS]);
    next_r.latch[BIT_LOP] = lop_chg
      || (rd_status ? (next_r.state == ST_LOP) : r.latch[BIT_LOP]);
    // pending until read, set wins over the read clear
    next_r.pend[BIT_AIS] = ais_chg || (r.pend[BIT_AIS] && !rd_pend);
    next_r.pend[BIT_LOP] = lop_chg || (r.pend[BIT_LOP] && !rd_pend);

    // Register writes; static overhead and options
    if (REG_WR) begin
      case (REG_ADDR)
        OFS_CTRL: begin
          next_r.sdh = REG_WDATA[CTRL_SDH];
          next_r.erdi = REG_WDATA[CTRL_ERDI];
          next_r.tx_len = REG_WDATA[CTRL_TXLEN +: 2];
          next_r.rx_len = REG_WDATA[CTRL_RXLEN +: 2];
        end
        OFS_MASK_A: next_r.mask_a = REG_WDATA[1:0];
        OFS_MASK_B: next_r.mask_b = REG_WDATA[1:0];
        OFS_TX_SIGNAL_LABEL: next_r.tx_signal_label = REG_WDATA[7:0];
        OFS_EXP_C2: next_r.exp_c2 = REG_WDATA[7:0];
        OFS_TX_USER_CHANNEL: next_r.f2 = REG_WDATA[7:0];
        OFS_TX_MULTIFRAME_IND: next_r.h4 = REG_WDATA[7:0];
        OFS_TX_GROWTH_A: next_r.z3 = REG_WDATA[7:0];
        OFS_TX_GROWTH_B: next_r.z4 = REG_WDATA[7:0];
        OFS_TX_TANDEM_OCTET: next_r.n1 = REG_WDATA[7:0];
        default: next_r.sdh = r.sdh;
      endcase
    end

    // interrupt lines follow masked pending bits
    next_r.irq_a = |(next_r.pend & next_r.mask_a);
    next_r.irq_b = |(next_r.pend & next_r.mask_b);

    // Read data, valid only in the cycle after the strobe
    next_r.rdata = 16'h0000;
    if (REG_RD) begin
      case (REG_ADDR)
        OFS_CTRL: next_r.rdata = {8'h00, r.rx_len, r.tx_len, 2'b00, r.erdi, r.sdh};
        OFS_PATH_STATUS: next_r.rdata = {10'h000, r.state, r.conc_err, r.plm, r.latch};
        OFS_PENDING: next_r.rdata = {14'h0000, r.pend};
        OFS_MASK_A: next_r.rdata = {14'h0000, r.mask_a};
        OFS_MASK_B: next_r.rdata = {14'h0000, r.mask_b};
        OFS_TX_SIGNAL_LABEL: next_r.rdata = {8'h00, r.tx_signal_label};
        OFS_EXP_C2: next_r.rdata = {8'h00, r.exp_c2};
        OFS_TX_USER_CHANNEL: next_r.rdata = {8'h00, r.f2};
        OFS_TX_MULTIFRAME_IND: next_r.rdata = {8'h00, r.h4};
        OFS_TX_GROWTH_A: next_r.rdata = {8'h00, r.z3};
        OFS_TX_GROWTH_B: next_r.rdata = {8'h00, r.z4};
        OFS_TX_TANDEM_OCTET: next_r.rdata = {8'h00, r.n1};
        OFS_PTR: next_r.rdata = {5'h00, r.have_ptr, r.ptr};
        default: next_r.rdata = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset into loss of pointer with no pointer
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      r <= '0;
      r.state <= ST_LOP;
      r.tx_len <= TRACE_16;
      r.rx_len <= TRACE_16;
      r.tx_signal_label <= RST_SIGNAL_LABEL;
      r.exp_c2 <= RST_SIGNAL_LABEL;
      r.f2 <= RST_OCTET;
      r.h4 <= RST_OCTET;
      r.z3 <= RST_OCTET;
      r.z4 <= RST_OCTET;
      r.n1 <= RST_OCTET;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flops
  assign REG_RDATA = r.rdata;
  assign PTR_STATE = r.state;
  assign PTR_VALUE = r.ptr;
  assign PTR_INC = r.inc;
  assign PTR_DEC = r.dec;
  assign LABEL_MISMATCH = r.plm;
  assign IRQ_OUT_A = r.irq_a;
  assign IRQ_OUT_B = r.irq_b;
  assign TX_SIGNAL_LABEL = r.tx_signal_label;
  assign TX_USER_CHANNEL = r.f2;
  assign TX_MULTIFRAME_IND = r.h4;
  assign TX_GROWTH_A = r.z3;
  assign TX_GROWTH_B = r.z4;
  assign TX_TANDEM_OCTET = r.n1;
  assign TX_TRACE_LENGTH = r.tx_len;
  assign RX_TRACE_LENGTH = r.rx_len;
  assign TX_ERDI_SEL = r.erdi;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // A third identical pointer outranks a justification and leaves hold-off alone
  property p_hold;
    (ndf_acc || ((inc_acc || dec_acc) && !pointer_normal_state_done)) |=> (r.hold == HOLD_FRAMES);
  endproperty
  a_hold: assert property (p_hold) else $error("hold-off not armed");

  property p_no_just_in_hold;
    (r.hold != 2'h0) |=> !(r.inc || r.dec);
  endproperty
  a_no_just_in_hold: assert property (p_no_just_in_hold) else $error("step in hold");

  property p_state_legal;
    r.state != 2'b11;
  endproperty
  a_state_legal: assert property (p_state_legal) else $error("illegal state");

  property p_ndf;
    ndf_acc |=> (r.state == ST_POINTER_NORMAL_STATE) && (r.ptr == $past(pval));
  endproperty
  a_ndf: assert property (p_ndf) else $error("new flag not adopted");

  property p_norm3;
    (pointer_normal_state_done && !ndf_acc) |=> (r.state == ST_POINTER_NORMAL_STATE) && (r.ptr == $past(pval));
  endproperty
  a_norm3: assert property (p_norm3) else $error("three normal not adopted");

  property p_ais;
    (ais_done && !ndf_acc && !pointer_normal_state_done) |=> (r.state == ST_AIS);
  endproperty
  a_ais: assert property (p_ais) else $error("alarm entry missed");

  property p_lop;
    (FRAME_STB && !valid_ptr && r.state != ST_LOP && r.inv_cnt == 4'h7 && !ais_done)
      |=> (r.state == ST_LOP);
  endproperty
  a_lop: assert property (p_lop) else $error("loss entry missed");

  property p_inc;
    (inc_acc && !pointer_normal_state_done) |=> r.inc
      && (r.ptr == (($past(r.ptr) == PTR_MAX) ? 10'h000 : $past(r.ptr) + 10'h001));
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");

  property p_ais_pend;
    ais_chg |=> r.pend[BIT_AIS] && r.latch[BIT_AIS];
  endproperty
  a_ais_pend: assert property (p_ais_pend) else $error("alarm event lost");

  property p_lop_irq;
    (lop_chg && !REG_WR) |=> (IRQ_OUT_A || !r.mask_a[BIT_LOP])
      && (IRQ_OUT_B || !r.mask_b[BIT_LOP]);
  endproperty
  a_lop_irq: assert property (p_lop_irq) else $error("loss irq missing");

  c_to_ais: cover property (ais_done);
  c_to_lop: cover property (lop_done);
  c_ndf: cover property (ndf_acc && r.state == ST_AIS);
  c_dec: cover property (dec_acc);
endmodule

// [tb/wpi_far_end.sv]
// Far-end path equipment model: sends one received frame per call of send.
// Assumes a single caller at a time and the receive frame clock on CLK.
`timescale 1ns/1ps
module wpi_far_end
  import wpi_pkg::*;
(
  input wire logic CLK,
  input wire logic SDH_MODE,
  output logic FRAME_STB,
  output logic [15:0] RX_PTR_WORD,
  output logic [15:0] RX_CONC_WORD,
  output logic [7:0] RX_C2
);
  logic [15:0] conc;

  ////////////////////////////////////////////////////////////////////////////
  // concatenation word coding
  assign conc = {FLAG_NEW, SDH_MODE ? SS_SDH : 2'h0, PTR_ONES};

  // Quiet lines until the first frame
  initial begin
    FRAME_STB = 1'b0;
    RX_PTR_WORD = 16'h0000;
    RX_CONC_WORD = 16'h0000;
    RX_C2 = 8'h00;
  end

  // Words are inverted after the strobe so stale data never passes as valid
  task automatic send(input logic [15:0] word, input logic [7:0] label);
    @(posedge CLK);
    FRAME_STB <= 1'b1;
    RX_PTR_WORD <= word;
    RX_CONC_WORD <= conc;
    RX_C2 <= label;
    @(posedge CLK);
    FRAME_STB <= 1'b0;
    RX_PTR_WORD <= ~word;
    RX_CONC_WORD <= ~conc;
    RX_C2 <= ~label;
  endtask
endmodule

// [tb/wis_pointer_interpreter_path_oh_tb_top.sv]
// Self-checking bench for the pointer interpreter and path overhead block.
// Assumes the far-end model drives frames; this module owns the register port.
`timescale 1ns/1ps
module wis_pointer_interpreter_path_oh_tb_top;
  import wpi_pkg::*;

  logic clk;
  logic reset_n;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic frame_stb;
  logic [15:0] ptr_word;
  logic [15:0] conc_word;
  logic [7:0] rx_c2;
  logic [1:0] ptr_state;
  logic [9:0] ptr_value;
  logic ptr_inc;
  logic ptr_dec;
  logic label_mm;
  logic irq_a;
  logic irq_b;
  logic [7:0] tx_oct [6];
  logic [1:0] tx_len;
  logic [1:0] rx_len;
  logic erdi;
  logic sdh;
  logic [7:0] lbl;
  logic [7:0] oct [7];
  logic [15:0] rdv;
  logic [9:0] cur;
  int failures;
  int compares;

  ////////////////////////////////////////////////////////////////////////////
  // Design and far end
  wpi_pointer_interp DUT (.CLK(clk), .RESET_N(reset_n), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .FRAME_STB(frame_stb), .RX_PTR_WORD(ptr_word), .RX_CONC_WORD(conc_word),
    .RX_C2(rx_c2), .PTR_STATE(ptr_state), .PTR_VALUE(ptr_value), .PTR_INC(ptr_inc),
    .PTR_DEC(ptr_dec), .LABEL_MISMATCH(label_mm), .IRQ_OUT_A(irq_a), .IRQ_OUT_B(irq_b),
    .TX_SIGNAL_LABEL(tx_oct[0]), .TX_USER_CHANNEL(tx_oct[1]),
    .TX_MULTIFRAME_IND(tx_oct[2]), .TX_GROWTH_A(tx_oct[3]), .TX_GROWTH_B(tx_oct[4]),
    .TX_TANDEM_OCTET(tx_oct[5]), .TX_TRACE_LENGTH(tx_len), .RX_TRACE_LENGTH(rx_len),
    .TX_ERDI_SEL(erdi));

  wpi_far_end far (.CLK(clk), .SDH_MODE(sdh), .FRAME_STB(frame_stb),
    .RX_PTR_WORD(ptr_word), .RX_CONC_WORD(conc_word), .RX_C2(rx_c2));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer word with the mode's SS bits
  function automatic logic [15:0] pw(input logic [3:0] f, input logic [9:0] p);
    return {f, sdh ? SS_SDH : 2'h0, p};
  endfunction

  // One justification step, wrapping at both ends
  function automatic logic [9:0] step(input logic [9:0] p, input logic up);
    if (up) return (p == PTR_MAX) ? 10'h000 : p + 10'h001;
    return (p == 10'h000) ? PTR_MAX : p - 10'h001;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Let the written register settle before anyone looks at its output
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rdv = reg_rdata;
  endtask

  task automatic frm(input int n, input logic [15:0] w);
    repeat (n) far.send(w, lbl);
    #1;
  endtask

  task automatic chk_ptr(input logic [1:0] st, input logic [9:0] v);
    check("state", 16'(ptr_state), 16'(st));
    check("value", 16'(ptr_value), 16'(v));
  endtask

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #1000000;
    failures++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sdh = 1'b0;
    lbl = RST_SIGNAL_LABEL;
    failures = 0;
    compares = 0;
    void'($urandom(78531));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk_ptr(ST_LOP, 10'h000);
    check("octets", {tx_oct[0], tx_oct[1]}, {RST_SIGNAL_LABEL, RST_OCTET});
    check("octets", 16'({tx_oct[2], tx_oct[3], tx_oct[4], tx_oct[5]} == 32'h0), 16'h1);
    rd(8'h3F);
    check("unmapped", rdv, 16'h0000);
    // Random octets; expected label stays at its default
    foreach (oct[i]) begin
      oct[i] = (i == 1) ? RST_SIGNAL_LABEL : 8'($urandom);
      wr(OFS_TX_SIGNAL_LABEL + 8'(i), {8'h00, oct[i]});
    end
    foreach (oct[i]) begin
      rd(OFS_TX_SIGNAL_LABEL + 8'(i));
      check("octet reg", rdv, {8'h00, oct[i]});
    end
    check("tx label", 16'(tx_oct[0]), 16'(oct[0]));
    for (int j = 1; j < 6; j++)
      check("tx octet", 16'(tx_oct[j]), 16'(oct[j + 1]));
    wr(OFS_CTRL, 16'h0092);
    check("ctrl", 16'({tx_len, rx_len, erdi}), 16'({TRACE_1, TRACE_64, 1'b1}));
    // SONET: acquisition, new data flag, hold-off, majority limits
    cur = 10'($urandom_range(781, 1));
    frm(2, pw(FLAG_POINTER_NORMAL_STATE, cur));
    check("state", 16'(ptr_state), 16'(ST_LOP));
    frm(1, pw(FLAG_POINTER_NORMAL_STATE, cur));
    chk_ptr(ST_POINTER_NORMAL_STATE, cur);
    cur = 10'($urandom_range(782, 0));
    frm(1, pw(FLAG_NEW, cur));
    chk_ptr(ST_POINTER_NORMAL_STATE, cur);
    frm(1, pw(FLAG_POINTER_NORMAL_STATE, cur ^ I_MASK));
    check("inc", 16'(ptr_inc), 16'h0000);
    frm(2, pw(4'h7, cur));
    chk_ptr(ST_POINTER_NORMAL_STATE, cur);
    frm(1, pw(FLAG_POINTER_NORMAL_STATE, cur ^ I_MASK ^ 10'h003));
    cur = step(cur, 1'b1);
    check("inc", 16'(ptr_inc), 16'h0001);
    chk_ptr(ST_POINTER_NORMAL_STATE, cur);
    frm(3, pw(FLAG_POINTER_NORMAL_STATE, cur));
    frm(1, pw(FLAG_POINTER_NORMAL_STATE, cur ^ D_MASK ^ 10'h007));
    check("dec", 16'(ptr_dec), 16'h0000);
    frm(1, pw(FLAG_POINTER_NORMAL_STATE, cur ^ D_MASK ^ 10'h003));
    cur = step(cur, 1'b0);
    check("dec", 16'(ptr_dec), 16'h0001);
    chk_ptr(ST_POINTER_NORMAL_STATE, cur);
    frm(1, pw(4'hB, PTR_MAX));
    chk_ptr(ST_POINTER_NORMAL_STATE, PTR_MAX);
    frm(3, pw(FLAG_POINTER_NORMAL_STATE, PTR_MAX));
    frm(1, pw(FLAG_POINTER_NORMAL_STATE, PTR_MAX ^ I_MASK));
    chk_ptr(ST_POINTER_NORMAL_STATE, 10'h000);
    // SDH majority rules
    sdh = 1'b1;
    wr(OFS_CTRL, 16'h0061);
    check("ctrl", 16'({tx_len, rx_len, erdi}), 16'({TRACE_64, TRACE_1, 1'b0}));
    cur = 10'($urandom_range(782, 0));
    frm(1, pw(FLAG_NEW, cur));
    frm(3, pw(FLAG_POINTER_NORMAL_STATE, cur));
    frm(1, pw(FLAG_POINTER_NORMAL_STATE, cur ^ 10'h03F));
    check("inc dec", 16'({ptr_inc, ptr_dec}), 16'h0000);
    chk_ptr(ST_POINTER_NORMAL_STATE, cur);
    frm(1, pw(FLAG_POINTER_NORMAL_STATE, cur ^ 10'h2A5));
    cur = step(cur, 1'b1);
    check("inc", 16'(ptr_inc), 16'h0001);
    chk_ptr(ST_POINTER_NORMAL_STATE, cur);
    frm(3, pw(FLAG_POINTER_NORMAL_STATE, cur));
    frm(1, pw(FLAG_POINTER_NORMAL_STATE, cur ^ 10'h15A));
    cur = step(cur, 1'b0);
    check("dec", 16'(ptr_dec), 16'h0001);
    chk_ptr(ST_POINTER_NORMAL_STATE, cur);
    // Clear events, then route alarm to A and loss to B
    rd(OFS_PENDING);
    rd(OFS_PATH_STATUS);
    rd(OFS_PATH_STATUS);
    wr(OFS_MASK_A, 16'h0001);
    wr(OFS_MASK_B, 16'h0002);
    rd(OFS_PENDING);
    check("pending", rdv, 16'h0000);
    check("irq", 16'({irq_a, irq_b}), 16'h0000);
    // Loss of pointer: SS mismatch counts as invalid
    frm(7, {FLAG_POINTER_NORMAL_STATE, 2'h1, cur});
    frm(1, pw(FLAG_POINTER_NORMAL_STATE, cur));
    frm(7, {FLAG_POINTER_NORMAL_STATE, 2'h1, cur});
    check("state", 16'(ptr_state), 16'(ST_POINTER_NORMAL_STATE));
    frm(1, {FLAG_POINTER_NORMAL_STATE, 2'h1, cur});
    check("state", 16'(ptr_state), 16'(ST_LOP));
    check("irq", 16'({irq_a, irq_b}), 16'h0001);
    frm(3, pw(FLAG_POINTER_NORMAL_STATE, cur));
    rd(OFS_PATH_STATUS);
    check("status", rdv & 16'h0033, 16'h0002);
    rd(OFS_PATH_STATUS);
    check("status", rdv & 16'h0033, 16'h0000);
    rd(OFS_PENDING);
    check("pending", rdv & 16'h0003, 16'h0002);
    // Alarm indication entry and exit
    frm(2, AIS_WORD);
    check("state", 16'(ptr_state), 16'(ST_POINTER_NORMAL_STATE));
    frm(1, AIS_WORD);
    check("state", 16'(ptr_state), 16'(ST_AIS));
    check("irq", 16'({irq_a, irq_b}), 16'h0002);
    frm(2, pw(FLAG_POINTER_NORMAL_STATE, cur));
    rd(OFS_PATH_STATUS);
    check("status", rdv & 16'h0033, 16'h0021);
    rd(OFS_PATH_STATUS);
    check("status", rdv & 16'h0033, 16'h0021);
    cur = 10'($urandom_range(782, 0));
    frm(1, pw(FLAG_NEW, cur));
    chk_ptr(ST_POINTER_NORMAL_STATE, cur);
    rd(OFS_PATH_STATUS);
    check("status", rdv & 16'h0033, 16'h0001);
    rd(OFS_PATH_STATUS);
    check("status", rdv & 16'h0033, 16'h0000);
    rd(OFS_PENDING);
    check("pending", rdv & 16'h0003, 16'h0001);
    rd(OFS_PENDING);
    check("pending", rdv, 16'h0000);
    check("irq", 16'({irq_a, irq_b}), 16'h0000);
    // Received label needs five equal frames before mismatch shows
    lbl = 8'h5C;
    frm(4, pw(FLAG_POINTER_NORMAL_STATE, cur));
    #40;
    check("label", 16'(label_mm), 16'h0000);
    frm(1, pw(FLAG_POINTER_NORMAL_STATE, cur));
    #40;
    check("label", 16'(label_mm), 16'h0001);
    conclude();
  end
endmodule
